// >>> rtl/ee2w_pkg.sv
// Purpose: shared constants and types for the two-wire serial eeprom target
// Assumes: mclk at 25 MHz, bus clock far slower than mclk
// Notes:   timing counts derived from the figures below
package ee2w_pkg;

  localparam int MEM_BYTES_DEF = 8192;
  localparam int ADDR_W_DEF    = 13;
  localparam int PAGE_W        = 5;
  localparam int PAGE_BYTES    = 32;
  localparam int BYTE_W        = 8;

  localparam int unsigned MCLK_HZ   = 25_000_000;
  localparam int unsigned T_WR_MS   = 5;
  // longest time, rounds down
  localparam int unsigned WR_CYCLES_DEF = T_WR_MS * (MCLK_HZ / 1000);

  // device-type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

  localparam int RW_BIT = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SEEN      = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b011,
    ST_TX   = 3'b010,
    ST_RACK = 3'b110,
    ST_PROG = 3'b111
  } ee2w_state_e;

  typedef enum logic [1:0] {
    K_DEV  = 2'h0,
    K_AHI  = 2'h1,
    K_ALO  = 2'h2,
    K_DATA = 2'h3
  } ee2w_kind_e;

  typedef struct packed {
    logic       sda;
    logic       scl;
    logic       wp;
    logic [2:0] strap;
  } ee2w_pins_s;

endpackage

// >>> rtl/ee2w_target.sv
// Purpose: two-wire serial eeprom target: addressing, page write, reads
// Assumes: sda is open drain, resolved outside; scl also clocks the capture flop
// Notes:   protocol runs on mclk from synchronised bus levels
`timescale 1ns/1ps
`default_nettype none

module ee2w_target
  import ee2w_pkg::*;
#(
  parameter int          MEM_BYTES = ee2w_pkg::MEM_BYTES_DEF,
  parameter int unsigned WR_CYCLES = ee2w_pkg::WR_CYCLES_DEF,
  parameter logic [3:0]  DEV_TYPE  = ee2w_pkg::DEV_TYPE_DEF
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic scl,
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe_n,
  input  wire logic wp,
  input  wire logic strap_addr_bit_hi,
  input  wire logic strap_addr_bit_mid,
  input  wire logic strap_addr_bit_lo,
  output var  logic write_busy
);

  import ee2w_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);
  localparam int TW = $clog2(WR_CYCLES + 1);
  localparam logic [TW-1:0] WR_LAST = TW'(WR_CYCLES - 1);
  localparam logic [PAGE_W:0] PAGE_END = (PAGE_W + 1)'(PAGE_BYTES);

  // link domain: bit sampled on the bus clock's own rising edge
  logic sda_cap_q;

  always_ff @(posedge scl) begin
    sda_cap_q <= sda_i;
  end

  // captured bit crosses into mclk through two flops
  logic cap_s1_q;
  logic cap_s2_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cap_s1_q <= 1'b1;
      cap_s2_q <= 1'b1;
    end else begin
      cap_s1_q <= sda_cap_q;
      cap_s2_q <= cap_s1_q;
    end
  end

  // pin synchronisers
  ee2w_pins_s pins_raw;
  ee2w_pins_s sync1_q;
  ee2w_pins_s sync2_q;
  ee2w_pins_s prev_q;

  // external pull-downs keep floating straps at zero
  assign pins_raw = '{sda: sda_i, scl: scl, wp: wp,
                      strap: {strap_addr_bit_hi, strap_addr_bit_mid, strap_addr_bit_lo}};

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_q <= '{sda: 1'b1, scl: 1'b1, wp: 1'b0, strap: 3'h0};
      sync2_q <= '{sda: 1'b1, scl: 1'b1, wp: 1'b0, strap: 3'h0};
      prev_q  <= '{sda: 1'b1, scl: 1'b1, wp: 1'b0, strap: 3'h0};
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // bus events
  wire start_ev = prev_q.scl & sync2_q.scl & prev_q.sda & ~sync2_q.sda;
  wire stop_ev  = prev_q.scl & sync2_q.scl & ~prev_q.sda & sync2_q.sda;
  wire rise_now = ~prev_q.scl & sync2_q.scl;
  wire fall_ev  = prev_q.scl & ~sync2_q.scl;

  // bit taken a cycle after the synced rise, so the crossed copy has settled
  logic rise_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rise_q <= 1'b0;
    end else begin
      rise_q <= rise_now;
    end
  end

  wire rise_ev  = rise_q;
  wire bit_in   = cap_s2_q;

  // state
  ee2w_state_e            state_q, state_d;
  ee2w_kind_e             kind_q, kind_d;
  logic [3:0]             cnt_q, cnt_d;
  logic [BYTE_W-1:0]      sh_q, sh_d;
  logic [AW-1:0]          ptr_q, ptr_d;
  logic [AW-PAGE_W-1:0]   page_q, page_d;
  logic [PAGE_BYTES-1:0]  mask_q, mask_d;
  logic                   oe_n_q, oe_n_d;
  logic                   rd_q, rd_d;
  logic                   wpend_q, wpend_d;
  logic [PAGE_W:0]        idx_q, idx_d;
  logic [TW-1:0]          timer_q, timer_d;
  logic                   buf_we;

  logic [BYTE_W-1:0] mem  [MEM_BYTES];
  logic [BYTE_W-1:0] pbuf [PAGE_BYTES];

  wire [BYTE_W-1:0]   mem_rd     = mem[ptr_q];
  wire [AW-1:0]       ptr_inc    = ptr_q + 1'b1;
  wire [PAGE_W-1:0]   page_off   = ptr_q[PAGE_W-1:0];
  wire [PAGE_W-1:0]   page_inc   = page_off + 1'b1;
  wire                addr_match = (sh_q[7:4] == DEV_TYPE)
                                 & (sh_q[3:1] == sync2_q.strap);
  wire                commit_on  = (idx_q != PAGE_END);
  wire [PAGE_W-1:0]   commit_idx = idx_q[PAGE_W-1:0];
  wire                in_prog    = (state_q == ST_PROG);
  wire                mem_we     = in_prog & commit_on
                                 & mask_q[commit_idx] & ~sync2_q.wp;
  wire [AW-1:0]       mem_wa     = {page_q, commit_idx};

  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    page_d  = page_q;
    mask_d  = mask_q;
    oe_n_d  = oe_n_q;
    rd_d    = rd_q;
    wpend_d = wpend_q;
    idx_d   = idx_q;
    timer_d = timer_q;
    buf_we  = 1'b0;
    if (in_prog) begin
      // bus is not looked at here, so polls get no acknowledge
      oe_n_d = 1'b1;
      // commit runs under the timer so the whole cycle stays within the limit
      if (commit_on) begin
        idx_d = idx_q + 1'b1;
      end
      if (timer_q != WR_LAST) begin
        timer_d = timer_q + 1'b1;
      end else if (!commit_on) begin
        state_d = ST_IDLE;
      end
    end else if (start_ev) begin
      state_d = ST_RX;
      kind_d  = K_DEV;
      cnt_d   = 4'h0;
      oe_n_d  = 1'b1;
      wpend_d = 1'b0;
      mask_d  = '0;
    end else if (stop_ev) begin
      oe_n_d = 1'b1;
      if (wpend_q) begin
        state_d = ST_PROG;
        idx_d   = '0;
        timer_d = '0;
        wpend_d = 1'b0;
      end else begin
        state_d = ST_IDLE;
      end
    end else begin
      case (state_q)
        ST_RX: begin
          if (rise_ev && cnt_q != BITS_PER_BYTE) begin
            sh_d  = {sh_q[BYTE_W-2:0], bit_in};
            cnt_d = cnt_q + 1'b1;
          end else if (fall_ev && cnt_q == BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            if (kind_q == K_DEV && !addr_match) begin
              state_d = ST_IDLE;
            end else begin
              oe_n_d  = 1'b0;
              state_d = ST_ACK;
              case (kind_q)
                K_DEV: begin
                  rd_d = sh_q[RW_BIT];
                end
                K_AHI: begin
                  ptr_d[AW-1:BYTE_W] = sh_q[AW-BYTE_W-1:0];
                end
                K_ALO: begin
                  ptr_d[BYTE_W-1:0] = sh_q;
                end
                default: begin
                  buf_we           = 1'b1;
                  mask_d[page_off] = 1'b1;
                  page_d           = ptr_q[AW-1:PAGE_W];
                  ptr_d            = {ptr_q[AW-1:PAGE_W], page_inc};
                  wpend_d          = 1'b1;
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (rise_ev) begin
            cnt_d = ACK_SEEN;
          end else if (fall_ev && cnt_q == ACK_SEEN) begin
            cnt_d = 4'h0;
            if (kind_q == K_DEV && rd_q) begin
              sh_d    = mem_rd;
              ptr_d   = ptr_inc;
              oe_n_d  = mem_rd[BYTE_W-1];
              state_d = ST_TX;
            end else begin
              oe_n_d  = 1'b1;
              state_d = ST_RX;
              case (kind_q)
                K_DEV:   kind_d = K_AHI;
                K_AHI:   kind_d = K_ALO;
                default: kind_d = K_DATA;
              endcase
            end
          end
        end
        ST_TX: begin
          if (rise_ev) begin
            cnt_d = cnt_q + 1'b1;
          end else if (fall_ev) begin
            if (cnt_q == BITS_PER_BYTE) begin
              oe_n_d  = 1'b1;
              cnt_d   = 4'h0;
              state_d = ST_RACK;
            end else begin
              oe_n_d = sh_q[BYTE_W-2];
              sh_d   = {sh_q[BYTE_W-2:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (rise_ev) begin
            if (bit_in) begin
              state_d = ST_IDLE;
            end else begin
              cnt_d = ACK_SEEN;
            end
          end else if (fall_ev && cnt_q == ACK_SEEN) begin
            sh_d    = mem_rd;
            ptr_d   = ptr_inc;
            oe_n_d  = mem_rd[BYTE_W-1];
            cnt_d   = 4'h0;
            state_d = ST_TX;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // frame tracking
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      kind_q  <= K_DEV;
      cnt_q   <= 4'h0;
      rd_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      cnt_q   <= cnt_d;
      rd_q    <= rd_d;
    end
  end

  // shifter and bus drive
  always_ff @(posedge mclk) begin
    if (reset) begin
      sh_q    <= 8'h00;
      oe_n_q  <= 1'b1;
    end else begin
      sh_q    <= sh_d;
      oe_n_q  <= oe_n_d;
    end
  end

  // address counter and page bookkeeping
  always_ff @(posedge mclk) begin
    if (reset) begin
      ptr_q   <= '0;
      page_q  <= '0;
      mask_q  <= '0;
      wpend_q <= 1'b0;
    end else begin
      ptr_q   <= ptr_d;
      page_q  <= page_d;
      mask_q  <= mask_d;
      wpend_q <= wpend_d;
    end
  end

  // write cycle progress
  always_ff @(posedge mclk) begin
    if (reset) begin
      idx_q   <= '0;
      timer_q <= '0;
    end else begin
      idx_q   <= idx_d;
      timer_q <= timer_d;
    end
  end

  // page buffer; wraps onto earlier bytes past 32
  always_ff @(posedge mclk) begin
    if (buf_we) begin
      pbuf[page_off] <= sh_q;
    end
  end

  // array storage
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_wa] <= pbuf[commit_idx];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sda_o      <= 1'b0;
      write_busy <= 1'b0;
    end else begin
      sda_o      <= 1'b0;
      write_busy <= (state_d == ST_PROG);
    end
  end

  assign sda_oe_n = oe_n_q;

endmodule // ee2w_target

`default_nettype wire

// >>> sim/ee2w_asserts.sv
// Purpose: port-level checks of the eeprom target
// Assumes: scl phases of 8 mclk, pull-up on sda
// Notes:   bound in the testbench top file
`timescale 1ns/1ps
`default_nettype none
module ee2w_asserts
  import ee2w_pkg::*;
#(
  parameter int unsigned WR_CYCLES = ee2w_pkg::WR_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic write_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  localparam int unsigned BUSY_MIN = WR_CYCLES;
  logic [15:0] busy_cnt_q;
  logic        seen_q;
  always_ff @(posedge mclk) begin
    busy_cnt_q <= (reset || !write_busy) ? 16'h0 : busy_cnt_q + 16'h1;
    seen_q     <= !reset && (seen_q || (scl && $fell(sda_i)));
  end
  property p_rst;
    @(posedge mclk) disable iff (1'b0) reset |=> sda_oe_n && !write_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("bad idle after reset");
  property p_od; !sda_o; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_quiet; write_busy |-> sda_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("drives sda while busy");
  property p_ack_low; $fell(sda_oe_n) |-> !scl; endproperty
  a_ack_low: assert property (p_ack_low) else $error("pull-down while scl high");
  property p_rel_low; $rose(sda_oe_n) |-> !scl; endproperty
  a_rel_low: assert property (p_rel_low) else $error("release while scl high");
  property p_hold; $fell(sda_oe_n) |-> !sda_oe_n [*4]; endproperty
  a_hold: assert property (p_hold) else $error("pull-down too short");
  property p_busy_go; $rose(write_busy) |-> scl && sda_i; endproperty
  a_busy_go: assert property (p_busy_go) else $error("write cycle without stop");
  property p_busy_len;
    $fell(write_busy) |-> busy_cnt_q >= BUSY_MIN - 1 && busy_cnt_q <= BUSY_MIN + 2;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length off");
  property p_pre; !seen_q |-> sda_oe_n; endproperty
  a_pre: assert property (p_pre) else $error("answer before start");
endmodule // ee2w_asserts
`default_nettype wire

// >>> sim/ee2w_ctl.sv
// Purpose: behavioural two-wire bus controller
// Assumes: open drain sda resolved by the bench
// Notes:   scl stands high between frames
`timescale 1ns/1ps
`default_nettype none
module ee2w_ctl (
  input  wire logic mclk,
  input  wire logic sda_bus,
  output var  logic scl,
  output var  logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic recover();
    int i;
    i = 0;
    sda = 1'b1; tk(4); scl = 1'b1; tk(4);
    while (!sda_bus && i < 9) begin
      scl = 1'b0; tk(8); scl = 1'b1; tk(4); i++;
    end
    sda = 1'b0; tk(4); scl = 1'b0; tk(4);
  endtask
  task automatic start();
    sda = 1'b1; tk(4); scl = 1'b1; tk(4); sda = 1'b0; tk(4); scl = 1'b0; tk(4);
  endtask
  task automatic stop();
    sda = 1'b0; tk(4); scl = 1'b1; tk(4); sda = 1'b1; tk(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda = b; tk(4); scl = 1'b1; tk(4); r = sda_bus; tk(4); scl = 1'b0; tk(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // ee2w_ctl
`default_nettype wire

// >>> sim/tb_ee2w_target.sv
// Purpose: self-checking bench of the eeprom target
// Assumes: 512-byte array, short write timer
// Notes:   straps 101, device type 9
`timescale 1ns/1ps
`default_nettype none
module tb_ee2w_target;
  import ee2w_pkg::*;
  localparam int unsigned WR_CYCLES = 400;
  localparam logic [7:0]  AW = 8'h9a;
  localparam logic [7:0]  AR = 8'h9b;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic       scl, sda_c, sda_o, sda_oe_n, write_busy, a;
  wire        sda_bus = sda_c & (sda_oe_n | sda_o);
  int         error_cnt = 0;
  int         tests_run = 0;
  logic [8:0] rows [5] = '{9'h19a, 9'h0b4, 9'h09c, 9'h098, 9'h01a};
  always #20 mclk = ~mclk;
  ee2w_ctl ctl (.mclk(mclk), .sda_bus(sda_bus), .scl(scl), .sda(sda_c));
  ee2w_target #(.MEM_BYTES(512), .WR_CYCLES(WR_CYCLES), .DEV_TYPE(4'h9)) dut (
    .mclk(mclk), .reset(reset), .scl(scl), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .wp(wp), .strap_addr_bit_hi(strap[2]),
    .strap_addr_bit_mid(strap[1]), .strap_addr_bit_lo(strap[0]), .write_busy(write_busy));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic poll();
    int n;
    logic k;
    n = 0;
    k = 1'b0;
    while (!k && n < 30) begin
      ctl.start(); ctl.wbyte(AW, k); ctl.stop(); n++;
    end
    chk(n > 1, 1'b1);
    if (!k) final_report();
  endtask
  task automatic head(input logic [12:0] ad);
    ctl.start(); ctl.wbyte(AW, a); chk(a, 1'b1);
    ctl.wbyte({3'h0, ad[12:8]}, a); chk(a, 1'b1);
    ctl.wbyte(ad[7:0], a); chk(a, 1'b1);
  endtask
  task automatic wr(input logic [12:0] ad, input logic [7:0] d [$]);
    head(ad);
    foreach (d[i]) begin
      ctl.wbyte(d[i], a); chk(a, 1'b1);
    end
    ctl.stop();
    poll();
  endtask
  task automatic rd(input logic [7:0] e [$]);
    logic [7:0] v;
    ctl.start(); ctl.wbyte(AR, a); chk(a, 1'b1);
    foreach (e[i]) begin
      ctl.rbyte(i == e.size() - 1, v); chk(v, e[i]);
    end
    ctl.stop();
  endtask
  task automatic rr(input logic [12:0] ad, input logic [7:0] e [$]);
    head(ad);
    rd(e);
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (rows[i]) begin
      ctl.start(); ctl.wbyte(rows[i][7:0], a); ctl.stop();
      chk(a, rows[i][8]);
    end
    wr(13'h1ff, '{8'hd1, 8'he2, 8'h63});
    rr(13'h1e0, '{8'he2});
    rd('{8'h63});
    wr(13'h000, '{8'h5c});
    rr(13'h1ff, '{8'hd1, 8'h5c});
    wp = 1'b1;
    wr(13'h000, '{8'haa});
    wp = 1'b0;
    rr(13'h000, '{8'h5c});
    head(13'h000);
    ctl.wbyte(8'h77, a);
    ctl.start(); ctl.stop(); ctl.tk(8);
    chk(write_busy, 1'b0);
    rr(13'h000, '{8'h5c});
    head(13'h000);
    ctl.start(); ctl.wbyte(AR, a); chk(a, 1'b1);
    ctl.recover();
    ctl.stop();
    rr(13'h000, '{8'h5c});
    final_report();
  end
endmodule // tb_ee2w_target
bind ee2w_target ee2w_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (.*);
`default_nettype wire
